// >>> logic/tcg_pkg.sv
// Purpose: Shared constants for the 16-bit timer control and gate pulse block.
// Assumes: Avalon-MM slave with 32-bit data and byte addresses.
// Notes: Offsets are byte addresses; each register takes one aligned word.
package tcg_pkg;

  // Register byte offsets.
  localparam logic [4:0] TCG_OFF_CONTROL = 5'h00;
  localparam logic [4:0] TCG_OFF_GATE = 5'h04;
  localparam logic [4:0] TCG_OFF_COUNT = 5'h08;
  localparam logic [4:0] TCG_OFF_STATUS = 5'h0C;
  localparam logic [4:0] TCG_OFF_MASK = 5'h10;

  // Control register field positions.
  localparam int TCG_CTL_RUN = 0;
  localparam int TCG_CTL_SYNC_BYPASS = 2;
  localparam int TCG_CTL_OSC_EN = 3;
  localparam int TCG_CTL_PRESCALE_LO = 4;
  localparam int TCG_CTL_CLKSEL_LO = 6;

  // Gate register field positions.
  localparam int TCG_GATE_LEVEL = 2;
  localparam int TCG_GATE_GO = 3;
  localparam int TCG_GATE_SPM = 4;
  localparam int TCG_GATE_TOGGLE = 5;
  localparam int TCG_GATE_POL = 6;
  localparam int TCG_GATE_EN = 7;

  // Status and mask bit positions.
  localparam int TCG_IRQ_OVERFLOW = 0;
  localparam int TCG_IRQ_GATE = 1;

  // Values after reset and the control write mask.
  localparam logic [7:0] TCG_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TCG_GATE_RESET = 8'h00;
  localparam logic [15:0] TCG_COUNT_RESET = 16'h0000;
  localparam logic [1:0] TCG_IRQ_RESET = 2'h0;
  localparam logic [7:0] TCG_CONTROL_WMASK = 8'hFD;

  // Count clock source codes.
  localparam logic [1:0] TCG_SRC_INSTR = 2'h0;
  localparam logic [1:0] TCG_SRC_SYS = 2'h1;
  localparam logic [1:0] TCG_SRC_EXT = 2'h2;
  localparam logic [1:0] TCG_SRC_CAP = 2'h3;

  // The instruction clock is the system clock divided by this many cycles.
  localparam int TCG_INSTR_DIV = 4;
  localparam logic [1:0] TCG_INSTR_LAST = 2'(TCG_INSTR_DIV - 1);
  localparam logic [15:0] TCG_COUNT_MAX = 16'hFFFF;

  // Single-pulse acquisition states.
  typedef enum logic [2:0]
  {
    TCG_SP_IDLE = 3'b001,
    TCG_SP_ARMED = 3'b010,
    TCG_SP_OPEN = 3'b100
  } tcg_sp_state_t;

endpackage

// >>> logic/tcg_edge_detect.sv
// Purpose: Rising edge detector with optional two-flop synchroniser.
// Assumes: One clock domain; the sample input may be asynchronous.
// Notes: With bypass high the raw input feeds the edge detector directly.
`timescale 1ns/1ps
module tcg_edge_detect
(
  input wire logic clock,
  input wire logic srst,
  input wire logic sample,
  input wire logic bypass,
  output logic rise
);

  // First stage, read only by the second stage.
  logic meta_q;
  logic meta_d;
  // Second stage of the synchroniser.
  logic sync_q;
  logic sync_d;
  // Previous level seen by the edge detector.
  logic prev_q;
  logic prev_d;
  // Level chosen for edge detection.
  logic level;

  // Choose the synchronised or the raw level and form the next values.
  always_comb
  begin
    meta_d = sample;
    sync_d = meta_q;
    level = bypass ? sample : sync_q;
    prev_d = level;
    rise = level & ~prev_q;
  end

  // Register the synchroniser and the edge history.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

endmodule

// >>> logic/tcg_timer.sv
// Purpose: 16-bit timer with clock select, prescaler, gate and single-pulse capture.
// Assumes: 200 MHz system clock; registers reached over Avalon-MM with waitrequest.
// Notes: External clocks are counted by rising edges sampled on the system clock.
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps

// Functional notes
// - Select instruction, system or capacitive clock
// - Source 10: pin edge or crystal
// - Prescale by 1, 2, 4 or 8
// - Oscillator enable bit drives oscillator circuit
// - External source: sync unless bypass set
// - Internal sources ignore the bypass bit
// - Run bit gates counting, holds count
// - Clearing run clears gate toggle flop
// - Control bit 1 reads zero, ignores writes
// - Software sets go; gate falling clears
// - Gate falling edge sets sticky event flag
// - Pulse starts once, later events ignored
// - Gate polarity selects counting level
// - Roll FFFF to 0000, set overflow
module tcg_timer
#(
  parameter int PRESCALE_WIDTH = 3
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic extCountClockPin,
  input wire logic crystalOscClock,
  input wire logic capSenseOsc,
  input wire logic gateInputPin,
  output logic dedicatedOscEnable,
  output logic irq
);
  import tcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Control register and gate register.
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic [7:0] gateCtl_q;
  logic [7:0] gateCtl_d;
  // The count register pair.
  logic [15:0] count_q;
  logic [15:0] count_d;
  // Sticky status, its mask and the interrupt output.
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic irq_d;
  // Bus answer registers.
  logic waitReq_q;
  logic waitReq_d;
  logic [31:0] readData_d;
  // Instruction clock divider and prescale counter.
  logic [1:0] instrDiv_q;
  logic [1:0] instrDiv_d;
  logic [PRESCALE_WIDTH-1:0] prescale_q;
  logic [PRESCALE_WIDTH-1:0] prescale_d;
  // Copy of the clock configuration to spot changes.
  logic [3:0] clkCfg_q;
  logic [3:0] clkCfg_d;
  // Gate toggle flop, gate history, current level and pulse state.
  logic toggle_q;
  logic toggle_d;
  logic gatePrev_q;
  logic gatePrev_d;
  logic level_q;
  logic level_d;
  tcg_sp_state_t spState_q;
  tcg_sp_state_t spState_d;
  // Outside source levels, their bypass choices and their rising edges.
  logic [2:0] srcLevel;
  logic [2:0] srcBypass;
  logic [2:0] srcRise;
  // Source tick, prescaled tick and helper terms.
  logic srcTick;
  logic countTick;
  logic [PRESCALE_WIDTH-1:0] prescaleLast;
  logic gateSignal;
  logic gateActive;
  logic gateFall;
  logic wrAccept;
  logic [7:0] wrByte;

  // Byte-lane merge for one lane of a write.
  function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [7:0] newv,
                                           input logic en);
    mergeByte = en ? newv : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Edge sources.

  // Lane 0 is the pin and lane 1 the crystal; both follow the bypass bit.
  // Lane 2 is the capacitive oscillator, which is internal and always synced.
  assign srcLevel = {capSenseOsc, crystalOscClock, extCountClockPin};
  assign srcBypass = {1'b0, {2{control_q[TCG_CTL_SYNC_BYPASS]}}};

  // One edge detector per outside source.
  for (genvar s = 0; s < 3; s++)
  begin : gSource
    tcg_edge_detect tcg_edge_detect_i
    (
      .clock(clock),
      .srst(srst),
      .sample(srcLevel[s]),
      .bypass(srcBypass[s]),
      .rise(srcRise[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count path: source select, prescaler, gate and counter.

  // Compute the next counter, prescaler and gate state.
  always_comb
  begin
    wrAccept = avs_write & ~waitReq_q;
    wrByte = avs_writedata[7:0];
    instrDiv_d = instrDiv_q + 2'h1;
    // Pick the tick for the selected source.
    unique case (control_q[TCG_CTL_CLKSEL_LO +: 2])
      TCG_SRC_INSTR: srcTick = (instrDiv_q == TCG_INSTR_LAST);
      TCG_SRC_SYS: srcTick = 1'b1;
      TCG_SRC_EXT: srcTick = control_q[TCG_CTL_OSC_EN] ? srcRise[1] : srcRise[0];
      TCG_SRC_CAP: srcTick = srcRise[2];
    endcase
    // Divide by 2**prescale; 00 passes every edge.
    prescaleLast = PRESCALE_WIDTH'((1 << control_q[TCG_CTL_PRESCALE_LO +: 2]) - 1);
    countTick = srcTick & (prescale_q == prescaleLast);
    clkCfg_d = control_q[7:4];
    if (clkCfg_q != control_q[7:4])
    begin
      prescale_d = '0;
      countTick = 1'b0;
    end
    else if (srcTick)
    begin
      prescale_d = (prescale_q == prescaleLast) ? '0 : prescale_q + 1'b1;
    end
    else
    begin
      prescale_d = prescale_q;
    end
    // Toggle flop changes on each rising gate edge; held clear when off or stopped.
    gatePrev_d = gateInputPin;
    if (!control_q[TCG_CTL_RUN] || !gateCtl_q[TCG_GATE_TOGGLE])
    begin
      toggle_d = 1'b0;
    end
    else
    begin
      toggle_d = toggle_q ^ (gateInputPin & ~gatePrev_q);
    end
    gateSignal = gateCtl_q[TCG_GATE_TOGGLE] ? toggle_q : gateInputPin;
    gateActive = gateCtl_q[TCG_GATE_POL] ? gateSignal : ~gateSignal;
    // Single-pulse sequencing: armed by software, opens once, closes on gate end.
    spState_d = spState_q;
    unique case (spState_q)
      TCG_SP_IDLE: spState_d = spState_q;
      TCG_SP_ARMED:
      begin
        if (gateActive)
        begin
          spState_d = TCG_SP_OPEN;
        end
      end
      TCG_SP_OPEN:
      begin
        if (!gateActive)
        begin
          spState_d = TCG_SP_IDLE;
        end
      end
      default: spState_d = TCG_SP_IDLE;
    endcase
    // Software write to the go bit; a one arms only from idle, a zero forces idle.
    if (wrAccept && avs_address == TCG_OFF_GATE && avs_byteenable[0])
    begin
      if (wrByte[TCG_GATE_GO])
      begin
        if (spState_q == TCG_SP_IDLE)
        begin
          spState_d = TCG_SP_ARMED;
        end
      end
      else
      begin
        spState_d = TCG_SP_IDLE;
      end
    end
    level_d = gateCtl_q[TCG_GATE_SPM] ? (spState_q == TCG_SP_OPEN) : gateActive;
    gateFall = level_q & ~level_d;
    // Counter: a bus write wins, else count when run and gate allow.
    count_d = count_q;
    if (wrAccept && avs_address == TCG_OFF_COUNT)
    begin
      count_d = {mergeByte(count_q[15:8], avs_writedata[15:8], avs_byteenable[1]),
                 mergeByte(count_q[7:0], avs_writedata[7:0], avs_byteenable[0])};
    end
    else if (control_q[TCG_CTL_RUN] && countTick &&
             (!gateCtl_q[TCG_GATE_EN] || level_q))
    begin
      count_d = count_q + 16'h0001;
    end
  end

  // Register the count path.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      count_q <= TCG_COUNT_RESET;
      instrDiv_q <= 2'h0;
      prescale_q <= '0;
      clkCfg_q <= TCG_CONTROL_RESET[7:4];
      toggle_q <= 1'b0;
      gatePrev_q <= 1'b0;
      level_q <= 1'b0;
      spState_q <= TCG_SP_IDLE;
    end
    else
    begin
      count_q <= count_d;
      instrDiv_q <= instrDiv_d;
      prescale_q <= prescale_d;
      clkCfg_q <= clkCfg_d;
      toggle_q <= toggle_d;
      gatePrev_q <= gatePrev_d;
      level_q <= level_d;
      spState_q <= spState_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, status and interrupt.

  // Decode bus accesses and compute register, status and answer values.
  always_comb
  begin
    control_d = control_q;
    gateCtl_d = gateCtl_q;
    mask_d = mask_q;
    status_d = status_q;
    // A write clears the status bits written with one.
    if (wrAccept && avs_address == TCG_OFF_STATUS && avs_byteenable[0])
    begin
      status_d = status_q & ~wrByte[1:0];
    end
    // Hardware sets win over a same-cycle clear.
    if (count_q == TCG_COUNT_MAX && count_d == TCG_COUNT_RESET &&
        !(wrAccept && avs_address == TCG_OFF_COUNT))
    begin
      status_d[TCG_IRQ_OVERFLOW] = 1'b1;
    end
    if (gateFall)
    begin
      status_d[TCG_IRQ_GATE] = 1'b1;
    end
    if (wrAccept && avs_byteenable[0])
    begin
      if (avs_address == TCG_OFF_CONTROL)
      begin
        control_d = wrByte & TCG_CONTROL_WMASK;
      end
      if (avs_address == TCG_OFF_GATE)
      begin
        gateCtl_d = {wrByte[7:4], 4'h0};
      end
      if (avs_address == TCG_OFF_MASK)
      begin
        mask_d = wrByte[1:0];
      end
    end
    irq_d = |(status_d & mask_d);
    // One wait cycle, then the answer for exactly one cycle.
    waitReq_d = ~((avs_read | avs_write) & waitReq_q);
    readData_d = 32'h0000_0000;
    if (avs_read && waitReq_q)
    begin
      unique case (avs_address)
        TCG_OFF_CONTROL: readData_d = {24'h000000, control_q};
        TCG_OFF_GATE: readData_d = {24'h000000, gateCtl_q[7:4],
                                    spState_q != TCG_SP_IDLE, level_q, 2'h0};
        TCG_OFF_COUNT: readData_d = {16'h0000, count_q};
        TCG_OFF_STATUS: readData_d = {30'h0, status_q};
        TCG_OFF_MASK: readData_d = {30'h0, mask_q};
        default: readData_d = 32'h0000_0000;
      endcase
    end
  end

  // Register the bus side.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      control_q <= TCG_CONTROL_RESET;
      gateCtl_q <= TCG_GATE_RESET;
      status_q <= TCG_IRQ_RESET;
      mask_q <= TCG_IRQ_RESET;
      irq <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      waitReq_q <= 1'b1;
      dedicatedOscEnable <= 1'b0;
    end
    else
    begin
      control_q <= control_d;
      gateCtl_q <= gateCtl_d;
      status_q <= status_d;
      mask_q <= mask_d;
      irq <= irq_d;
      avs_waitrequest <= waitReq_d;
      avs_readdata <= readData_d;
      waitReq_q <= waitReq_d;
      dedicatedOscEnable <= control_d[TCG_CTL_OSC_EN];
    end
  end

endmodule

// >>> test/tcg_timer_properties.sv
// Purpose: Bus, reset and control register properties of the timer block.
// Assumes: One clock domain; sees only the top module ports.
// Notes: A shadow byte mirrors every accepted control write.
`timescale 1ns/1ps
module tcg_timer_properties
  import tcg_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 3
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic extCountClockPin,
  input wire logic crystalOscClock,
  input wire logic capSenseOsc,
  input wire logic gateInputPin,
  input wire logic dedicatedOscEnable,
  input wire logic irq
);
  logic [7:0] ctlShadow_q; // Control byte as software left it.
  logic [7:0] ctlShadow_d; // Next shadow value.
  logic ctlWrite; // A control write takes effect at this edge.
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  assign ctlWrite = avs_write && !avs_waitrequest && avs_address == TCG_OFF_CONTROL
    && avs_byteenable[0];
  // Bit 1 has no storage, so the shadow drops it.
  always_comb
  begin
    ctlShadow_d = ctlWrite ? (avs_writedata[7:0] & 8'hFD) : ctlShadow_q;
  end
  // Registers the shadow.
  always_ff @(posedge clock)
  begin
    ctlShadow_q <= srst ? 8'h00 : ctlShadow_d;
  end
  sequence s_read_ctl;
    avs_read && avs_waitrequest && avs_address == TCG_OFF_CONTROL ##1 !avs_waitrequest;
  endsequence
  property p_answer_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_answer_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_idle_wait;
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_data_quiet;
    avs_waitrequest |-> avs_readdata == 32'h0;
  endproperty
  property p_bit1_zero;
    s_read_ctl |-> avs_readdata[1] == 1'b0;
  endproperty
  property p_ctl_readback;
    s_read_ctl |-> avs_readdata == {24'h0, ctlShadow_q};
  endproperty
  property p_osc_follow;
    ctlWrite |=> dedicatedOscEnable == $past(avs_writedata[3]);
  endproperty
  property p_osc_hold;
    !$stable(dedicatedOscEnable) |-> $past(ctlWrite);
  endproperty
  property p_reset_quiet;
    $past(srst) |-> avs_waitrequest && !irq && !dedicatedOscEnable;
  endproperty
  a_answer_one: assert property (p_answer_one) else $error("no answer one cycle after request");
  a_answer_once: assert property (p_answer_once) else $error("answer stood over one cycle");
  a_idle_wait: assert property (p_idle_wait) else $error("answer without a request");
  a_data_quiet: assert property (p_data_quiet) else $error("read data not zero when idle");
  a_bit1_zero: assert property (p_bit1_zero) else $error("control bit 1 read as one");
  a_ctl_readback: assert property (p_ctl_readback) else $error("control readback wrong");
  a_osc_follow: assert property (p_osc_follow) else $error("osc enable missed write");
  a_osc_hold: assert property (p_osc_hold) else $error("osc enable moved alone");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not at reset");
endmodule
bind tcg_timer tcg_timer_properties #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) tcg_timer_properties_i (
  .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .extCountClockPin(extCountClockPin), .crystalOscClock(crystalOscClock),
  .capSenseOsc(capSenseOsc), .gateInputPin(gateInputPin),
  .dedicatedOscEnable(dedicatedOscEnable), .irq(irq));

// >>> test/tcg_clock_source_model.sv
// Purpose: Outside clock sources: pin clock, crystal and sensing oscillator.
// Assumes: Periods of 8, 16 and 32 system cycles keep the sources apart.
// Notes: The crystal only swings while the block enables its oscillator.
`timescale 1ns/1ps
module tcg_clock_source_model
(
  input wire logic clock,
  input wire logic oscEnable,
  output logic extPin,
  output logic crystal,
  output logic cap_sense_osc
);
  logic [4:0] phase = 5'h00; // Free running phase of all sources.
  // Advances the phase every system cycle.
  always @(posedge clock)
  begin
    phase <= phase + 5'h01;
  end
  assign extPin = phase[2];
  assign crystal = oscEnable & phase[3];
  assign cap_sense_osc = phase[4];
endmodule

// >>> test/tcg_timer_bench.sv
// Purpose: Self-checking bench for the timer block over its register bus.
// Assumes: Pin clock period 8, crystal 16, sensing oscillator 32 cycles.
// Notes: Counts over a span are checked within a small window.
`timescale 1ns/1ps
`define CHECK_EQ(what, exp, got) \
  begin totalChecks++; if ((got) !== (exp)) begin badCount++; \
  $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module tcg_timer_bench;
  import tcg_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic extPin, crystal, cap_sense_osc, oscEn, irq;
  logic gatePin = 1'b0;
  logic [31:0] q, c;
  int badCount = 0;
  int totalChecks = 0;
  int lo; // Lower bound of the count window of one span.
  logic [7:0] cfg [11] = '{8'h00, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h44, 8'h80, 8'h84,
    8'h88, 8'hC0};
  int dv [11] = '{4, 32, 1, 2, 4, 8, 1, 8, 8, 16, 32};
  logic [4:0] offs [6] = '{TCG_OFF_CONTROL, TCG_OFF_GATE, TCG_OFF_COUNT, TCG_OFF_STATUS,
    TCG_OFF_MASK, 5'h14};
  tcg_timer #(.PRESCALE_WIDTH(3)) tcg_timer_i (.clock(clock), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .extCountClockPin(extPin), .crystalOscClock(crystal), .capSenseOsc(cap_sense_osc),
    .gateInputPin(gatePin), .dedicatedOscEnable(oscEn), .irq(irq));
  tcg_clock_source_model tcg_clock_source_model_i (.clock(clock), .oscEnable(oscEn),
    .extPin(extPin), .crystal(crystal), .cap_sense_osc(cap_sense_osc));
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  // One bus access, held until waitrequest is seen low.
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= (a == TCG_OFF_COUNT) ? 4'h3 : 4'h1;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) badCount++;
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    acc(1'b0, a, 32'h0, r);
  endtask
  // Counts from zero for k cycles under one configuration.
  task automatic span(input logic [7:0] ctl, input int k, output logic [31:0] r);
    wr(TCG_OFF_COUNT, 32'h0);
    wr(TCG_OFF_CONTROL, {24'h0, ctl | 8'h01});
    repeat (k) @(posedge clock);
    wr(TCG_OFF_CONTROL, {24'h0, ctl});
    rd(TCG_OFF_COUNT, r);
  endtask
  task automatic pulse();
    gatePin <= 1'b1;
    repeat (40) @(posedge clock);
    gatePin <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clock);
    badCount++;
    giveVerdict();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    foreach (offs[i])
    begin
      rd(offs[i], q);
      // A low gate pin with polarity zero is active, so the level bit reads one.
      `CHECK_EQ("reset value", (offs[i] == TCG_OFF_GATE) ? 32'h4 : 32'h0, q)
    end
    wr(TCG_OFF_CONTROL, 32'hFF);
    `CHECK_EQ("osc enable", 1'b1, oscEn)
    rd(TCG_OFF_CONTROL, q);
    `CHECK_EQ("control", 32'hFD, q)
    wr(TCG_OFF_CONTROL, 32'h0);
    `CHECK_EQ("osc enable", 1'b0, oscEn)
    foreach (cfg[i])
    begin
      span(cfg[i], 512, c);
      lo = 512 / dv[i] - 2;
      `CHECK_EQ("count span", 1'b1, c >= lo && c <= lo + 6)
      repeat (20) @(posedge clock);
      rd(TCG_OFF_COUNT, q);
      `CHECK_EQ("held count", c, q)
    end
    wr(TCG_OFF_COUNT, 32'hFFFE);
    wr(TCG_OFF_CONTROL, 32'h41);
    repeat (8) @(posedge clock);
    wr(TCG_OFF_CONTROL, 32'h40);
    rd(TCG_OFF_STATUS, q);
    `CHECK_EQ("status", 32'h1, q)
    `CHECK_EQ("irq masked", 1'b0, irq)
    wr(TCG_OFF_MASK, 32'h1);
    repeat (2) @(posedge clock);
    `CHECK_EQ("irq", 1'b1, irq)
    wr(TCG_OFF_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    `CHECK_EQ("irq cleared", 1'b0, irq)
    wr(TCG_OFF_GATE, 32'hC0);
    span(8'h40, 64, c);
    `CHECK_EQ("gated count", 32'h0, c)
    wr(TCG_OFF_GATE, 32'h80);
    span(8'h40, 64, c);
    `CHECK_EQ("open count", 1'b1, c >= 62 && c <= 68)
    wr(TCG_OFF_STATUS, 32'h3);
    gatePin <= 1'b1;
    repeat (4) @(posedge clock);
    rd(TCG_OFF_STATUS, q);
    `CHECK_EQ("gate event", 32'h2, q)
    wr(TCG_OFF_STATUS, 32'h2);
    rd(TCG_OFF_STATUS, q);
    `CHECK_EQ("event cleared", 32'h0, q)
    gatePin <= 1'b0;
    wr(TCG_OFF_COUNT, 32'h0);
    wr(TCG_OFF_GATE, 32'hD8);
    rd(TCG_OFF_GATE, q);
    `CHECK_EQ("go armed", 32'hD8, q)
    wr(TCG_OFF_CONTROL, 32'h41);
    pulse();
    rd(TCG_OFF_GATE, q);
    `CHECK_EQ("go done", 32'hD0, q)
    rd(TCG_OFF_COUNT, c);
    `CHECK_EQ("pulse count", 1'b1, c >= 30 && c <= 50)
    pulse();
    rd(TCG_OFF_COUNT, q);
    `CHECK_EQ("second pulse", c, q)
    rd(TCG_OFF_STATUS, q);
    `CHECK_EQ("pulse event", 1'b1, q[1])
    // Toggle mode: one rising gate edge opens the gate until run is cleared.
    wr(TCG_OFF_GATE, 32'hE0);
    pulse();
    rd(TCG_OFF_COUNT, q);
    `CHECK_EQ("toggle count", 1'b1, q > c)
    wr(TCG_OFF_CONTROL, 32'h40);
    wr(TCG_OFF_CONTROL, 32'h41);
    rd(TCG_OFF_COUNT, c);
    repeat (20) @(posedge clock);
    rd(TCG_OFF_COUNT, q);
    `CHECK_EQ("toggle cleared", c, q)
    giveVerdict();
  end
endmodule
